// ===== hdl/qaid_pkg.sv
// constants of the quad analog input readout and its diagnostic record
// assumes a single 100 MHz core clock
package qaid_pkg;
   // ----------------------------------------------------------------
   // clocking
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 100_000_000; // core clock rate
   localparam int unsigned TICK_US = 1; // ticker resolution in us
   localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

   // ----------------------------------------------------------------
   // function codes
   // ----------------------------------------------------------------
   localparam logic [7:0] FN_FMT_A = 8'h10; // 10 V reads 27648
   localparam logic [7:0] FN_FMT_B = 8'h20; // 10 V reads 16384
   localparam logic [7:0] FN_OFF = 8'hFF; // channel deactivated
   localparam logic [7:0] FN_RESET = 8'h10; // function code after reset

   // ----------------------------------------------------------------
   // scaling: value = (millivolts * gain) >>> 16
   // ----------------------------------------------------------------
   // gains rounded up: a floored product must land 10 V on its code
   localparam logic signed [18:0] GAIN_A = 19'sh2C3CA; // 27648/10000
   localparam logic signed [18:0] GAIN_B = 19'sh1A36F; // 16384/10000
   localparam logic signed [15:0] MAX_A = 16'sh7EFF; // overrange top
   localparam logic signed [15:0] MIN_A = 16'shED00; // underrange bottom
   localparam logic signed [15:0] MAX_B = 16'sh5000;
   localparam logic signed [15:0] MIN_B = 16'shF333;

   // ----------------------------------------------------------------
   // access paths and addresses
   // ----------------------------------------------------------------
   localparam logic [1:0] PATH_RECORD = 2'h0; // record number path
   localparam logic [1:0] PATH_INDEX = 2'h1; // object index path
   localparam logic [1:0] PATH_SUB = 2'h2; // index plus subindex path
   localparam logic [15:0] REC_DIAG_SHORT = 16'h0000;
   localparam logic [15:0] REC_DIAG_FULL = 16'h0001;
   localparam logic [15:0] REC_FN_BASE = 16'h0080;
   localparam logic [15:0] IDX_DIAG_SHORT = 16'h2F00;
   localparam logic [15:0] IDX_DIAG_FULL = 16'h2F01;
   localparam logic [15:0] IDX_FN_BASE = 16'h3100;
   localparam logic [15:0] IDX_SUB_DIAG = 16'h5005;
   localparam logic [7:0] SUB_FN_BASE = 8'h01; // first function subindex
   localparam logic [7:0] SUB_DIAG_BASE = 8'h02; // subindex of byte 0
   localparam int unsigned SHORT_LEN = 4; // bytes of the short record
   localparam int unsigned DIAG_LEN = 20; // bytes of the full record

   // ----------------------------------------------------------------
   // record byte positions and constant bytes
   // ----------------------------------------------------------------
   localparam int unsigned BY_SUMMARY = 0;
   localparam int unsigned BY_MODINFO = 1;
   localparam int unsigned BY_INTERNAL = 3;
   localparam int unsigned BY_KIND = 4;
   localparam int unsigned BY_NBITS = 5;
   localparam int unsigned BY_NCH = 6;
   localparam int unsigned BY_CHSUM = 7;
   localparam int unsigned BY_CH0 = 8;
   localparam int unsigned BY_TS = 16; // timestamp, msb first
   localparam logic [7:0] MODINFO_VAL = 8'h15; // analog, chan info
   localparam logic [7:0] KIND_VAL = 8'h71; // analog input
   localparam logic [7:0] NBITS_VAL = 8'h08;
   localparam logic [7:0] NCH_VAL = 8'h04;

   // ----------------------------------------------------------------
   // bit positions
   // ----------------------------------------------------------------
   localparam int unsigned SUM_FAIL = 0;
   localparam int unsigned SUM_INT = 1;
   localparam int unsigned SUM_EXT = 2;
   localparam int unsigned SUM_CHAN = 3;
   localparam int unsigned SUM_AUX = 4;
   localparam int unsigned SUM_PARAM = 7;
   localparam int unsigned INT_OVFL = 3;
   localparam int unsigned INT_COMM = 4;
   localparam int unsigned CH_PARAM = 0;
   localparam int unsigned CH_UNDER = 6;
   localparam int unsigned CH_OVER = 7;
endpackage

// ===== hdl/qaid_scale_if.sv
// bundle between the readout top and one channel scaler
// assumes both ends sit on the same core clock
`timescale 1ns/100ps
interface qaid_scale_if;
   logic [7:0] fn_code; // channel function select
   logic sample_stb; // new sample present
   logic signed [15:0] sample_mv; // sample in millivolts
   logic signed [15:0] value; // scaled value
   logic over; // measuring range overflow
   logic under; // measuring range underflow
   logic param_err; // unknown function code

   // top side drives code and samples
   modport top (
      output fn_code, sample_stb, sample_mv,
      input value, over, under, param_err
   );
   // scaler side answers with value and flags
   modport scaler (
      input fn_code, sample_stb, sample_mv,
      output value, over, under, param_err
   );
endinterface

// ===== hdl/qaid_scale.sv
// one channel scaler: millivolts to the selected signed encoding
// assumes samples arrive as one-cycle strobes on the core clock
`timescale 1ns/100ps
module qaid_scale (
   input wire logic core_clk_in, // core clock
   input wire logic rst_in, // synchronous reset, high
   qaid_scale_if.scaler sif // code, sample and answer
);
   // ----------------------------------------------------------------
   // gain and limits per function code
   // ----------------------------------------------------------------
   logic signed [18:0] gain; // selected gain
   logic signed [15:0] lim_hi; // selected upper limit
   logic signed [15:0] lim_lo; // selected lower limit
   logic known; // code measures
   logic signed [34:0] prod; // full product
   logic signed [18:0] raw; // scaled, before clamp

   // pick encoding from the function code
   always_comb begin
      gain = qaid_pkg::GAIN_A;
      lim_hi = qaid_pkg::MAX_A;
      lim_lo = qaid_pkg::MIN_A;
      known = 1'b1;
      case (sif.fn_code)
         qaid_pkg::FN_FMT_A: begin
            gain = qaid_pkg::GAIN_A;
         end
         qaid_pkg::FN_FMT_B: begin
            gain = qaid_pkg::GAIN_B;
            lim_hi = qaid_pkg::MAX_B;
            lim_lo = qaid_pkg::MIN_B;
         end
         default: begin
            known = 1'b0; // off or unknown
         end
      endcase
   end

   // linear scale, zero volts gives zero
   assign prod = 35'(sif.sample_mv * gain);
   assign raw = prod[34:16];

   // ----------------------------------------------------------------
   // value register with clamp and range flags
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sif.value <= 16'sh0000;
         sif.over <= 1'b0;
         sif.under <= 1'b0;
      end else if (!known) begin
         // deactivated or bad code: no measurement
         sif.value <= 16'sh0000;
         sif.over <= 1'b0;
         sif.under <= 1'b0;
      end else if (sif.sample_stb) begin
         if (raw > 19'(lim_hi)) begin
            sif.value <= lim_hi;
            sif.over <= 1'b1;
            sif.under <= 1'b0;
         end else if (raw < 19'(lim_lo)) begin
            sif.value <= lim_lo;
            sif.over <= 1'b0;
            sif.under <= 1'b1;
         end else begin
            sif.value <= raw[15:0];
            sif.over <= 1'b0;
            sif.under <= 1'b0;
         end
      end
   end

   // unknown code is a parameter error, off is not
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sif.param_err <= 1'b0;
      end else begin
         sif.param_err <= !known && (sif.fn_code != qaid_pkg::FN_OFF);
      end
   end
endmodule // qaid_scale

// ===== hdl/qaid_top.sv
// quad analog input readout: scaling, diagnostic record, access port
// assumes one 100 MHz clock; status pins are asynchronous
// What this block does
// - code 10h: 10 V reads 27648
// - code 10h clamps at 7EFFh and ED00h
// - code 20h: 10 V reads 16384
// - code 20h clamps at 5000h and F333h
// - code FFh deactivates the channel
// - channel errors light channel indicator and record
// - no interrupt; record read only
// - record 01h full, 00h first four
// - index 2F01h full, 2F00h first four
// - index 5005h, one subindex per byte
// - summary byte flag bits 0-4, 7
// - internal byte: overflow bit 3, comms 4
// - channel kind reads 71h
// - diagnostic bits per channel reads 08h
// - channel count reads 04h
// - channel byte: param 0, under 6, over 7
// - free running 32-bit microsecond counter
// - latch counter on each diagnostic event
`timescale 1ns/100ps
module qaid_top #(
   parameter int unsigned NCH = 4 // channel count
) (
   input wire logic core_clk_in, // core clock
   input wire logic rst_in, // synchronous reset, high
   input wire logic sample_stb_in, // conversion done pulse
   input wire logic [NCH*16-1:0] sample_mv_in, // mv per channel
   input wire logic module_fail_in, // module failure pin
   input wire logic aux_missing_in, // aux supply missing pin
   input wire logic diag_ovfl_in, // diag buffer overflow pin
   input wire logic comm_err_in, // internal comms error pin
   input wire logic req_valid_in, // access request
   input wire logic req_write_in, // request is a write
   input wire logic [1:0] req_path_in, // record, index, subindex
   input wire logic [15:0] req_addr_in, // record number or index
   input wire logic [7:0] req_sub_in, // byte offset or subindex
   input wire logic [7:0] req_wdata_in, // write byte
   output logic rsp_valid_out, // answer pulse
   output logic [7:0] rsp_data_out, // read byte
   output logic rsp_err_out, // unmapped or refused
   output logic [NCH*16-1:0] value_out, // scaled values
   output logic [NCH-1:0] chan_led_out, // channel error indicators
   output logic module_led_out // module error indicator
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] pin_s1_r; // first stage, read only by stage two
   logic [3:0] pin_s2_r; // usable pin levels

   // two flops per asynchronous status pin
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pin_s1_r <= 4'h0;
         pin_s2_r <= 4'h0;
      end else begin
         pin_s1_r <= {comm_err_in, diag_ovfl_in, aux_missing_in,
                      module_fail_in};
         pin_s2_r <= pin_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // microsecond ticker
   // ----------------------------------------------------------------
   localparam logic [7:0] TICK_LAST = 8'(qaid_pkg::TICK_CYC - 1);
   logic [7:0] div_r; // cycle divider
   logic tick; // one-cycle enable per microsecond
   logic [31:0] us_r; // microsecond counter

   assign tick = (div_r == TICK_LAST);

   // divide core clock down to a microsecond enable
   always_ff @(posedge core_clk_in) begin
      if (rst_in || tick) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end

   // counter starts at zero and wraps after all ones
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         us_r <= 32'h0000_0000;
      end else if (tick) begin
         us_r <= us_r + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // function select and channel scalers
   // ----------------------------------------------------------------
   logic [7:0] fn_r [NCH]; // channel_function_select per channel
   logic [NCH-1:0] fn_wr; // write strobe per channel
   logic [7:0] ch_err [NCH]; // chanN_error_flags
   logic [NCH-1:0] ch_any; // channel has any flag

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         qaid_scale_if sif ();

         assign sif.fn_code = fn_r[g];
         assign sif.sample_stb = sample_stb_in;
         assign sif.sample_mv = sample_mv_in[g*16 +: 16];

         qaid_scale u_scale (
            .core_clk_in (core_clk_in),
            .rst_in (rst_in),
            .sif (sif.scaler)
         );

         // hold function code, reset to default
         always_ff @(posedge core_clk_in) begin
            if (rst_in) begin
               fn_r[g] <= qaid_pkg::FN_RESET;
            end else if (fn_wr[g]) begin
               fn_r[g] <= req_wdata_in;
            end
         end

         // per-channel error byte, unused bits zero
         always_comb begin
            ch_err[g] = 8'h00;
            ch_err[g][qaid_pkg::CH_PARAM] = sif.param_err;
            ch_err[g][qaid_pkg::CH_UNDER] = sif.under;
            ch_err[g][qaid_pkg::CH_OVER] = sif.over;
         end

         assign ch_any[g] = |ch_err[g];
         assign value_out[g*16 +: 16] = sif.value;
      end
   endgenerate

   // ----------------------------------------------------------------
   // diagnostic flags
   // ----------------------------------------------------------------
   logic [7:0] summary; // diag_summary_flags
   logic [7:0] internal; // diag_internal_flags
   logic [7:0] ch_sum; // channel_error_summary
   logic param_any; // any channel parameter error
   logic range_any; // any channel range error

   // collect channel-level causes
   always_comb begin
      param_any = 1'b0;
      range_any = 1'b0;
      ch_sum = 8'h00;
      for (int i = 0; i < NCH; i++) begin
         param_any = param_any | ch_err[i][qaid_pkg::CH_PARAM];
         range_any = range_any | ch_err[i][qaid_pkg::CH_UNDER]
                     | ch_err[i][qaid_pkg::CH_OVER];
         ch_sum[i] = ch_any[i];
      end
   end

   // internal byte, reserved bits zero
   always_comb begin
      internal = 8'h00;
      internal[qaid_pkg::INT_OVFL] = pin_s2_r[2];
      internal[qaid_pkg::INT_COMM] = pin_s2_r[3];
   end

   // summary byte, bits 6 and 5 stay zero
   always_comb begin
      summary = 8'h00;
      summary[qaid_pkg::SUM_FAIL] = pin_s2_r[0];
      summary[qaid_pkg::SUM_INT] = |internal;
      summary[qaid_pkg::SUM_EXT] = pin_s2_r[1] | range_any;
      summary[qaid_pkg::SUM_CHAN] = |ch_any;
      summary[qaid_pkg::SUM_AUX] = pin_s2_r[1];
      summary[qaid_pkg::SUM_PARAM] = param_any;
   end

   // ----------------------------------------------------------------
   // event timestamp
   // ----------------------------------------------------------------
   localparam int unsigned FLAG_W = 24 + 8 * NCH; // watched flag bits
   logic [FLAG_W-1:0] flags; // all record flags
   logic [FLAG_W-1:0] flags_prev_r; // flags one cycle ago
   logic [31:0] stamp_r; // diag_timestamp_us

   always_comb begin
      flags = {summary, internal, ch_sum, {FLAG_W-24{1'b0}}};
      for (int i = 0; i < NCH; i++) begin
         flags[i*8 +: 8] = ch_err[i];
      end
   end

   // a newly raised flag is an event
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         flags_prev_r <= '0;
         stamp_r <= 32'h0000_0000;
      end else begin
         flags_prev_r <= flags;
         if (|(flags & ~flags_prev_r)) begin
            stamp_r <= us_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // indicators
   // ----------------------------------------------------------------
   // channel indicator on any error of that channel
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         chan_led_out <= '0;
         module_led_out <= 1'b0;
      end else begin
         chan_led_out <= ch_any;
         module_led_out <= |summary;
      end
   end

   // ----------------------------------------------------------------
   // diagnostic record image
   // ----------------------------------------------------------------
   logic [7:0] rec [qaid_pkg::DIAG_LEN]; // record bytes

   // assemble record; spare bytes read zero
   always_comb begin
      for (int i = 0; i < qaid_pkg::DIAG_LEN; i++) begin
         rec[i] = 8'h00;
      end
      rec[qaid_pkg::BY_SUMMARY] = summary;
      rec[qaid_pkg::BY_MODINFO] = qaid_pkg::MODINFO_VAL;
      rec[qaid_pkg::BY_INTERNAL] = internal;
      rec[qaid_pkg::BY_KIND] = qaid_pkg::KIND_VAL;
      rec[qaid_pkg::BY_NBITS] = qaid_pkg::NBITS_VAL;
      rec[qaid_pkg::BY_NCH] = qaid_pkg::NCH_VAL;
      rec[qaid_pkg::BY_CHSUM] = ch_sum;
      for (int i = 0; i < NCH; i++) begin
         rec[qaid_pkg::BY_CH0 + i] = ch_err[i];
      end
      for (int i = 0; i < 4; i++) begin
         rec[qaid_pkg::BY_TS + i] = stamp_r[31 - 8*i -: 8];
      end
   end

   // ----------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------
   logic diag_hit; // request addresses the record
   logic [7:0] diag_len; // bytes visible on that path
   logic [7:0] diag_byte; // byte offset inside record
   logic fn_hit; // request addresses a function code
   logic [7:0] fn_sel; // channel of that function code

   // decode path, address and byte into record or function select
   always_comb begin
      diag_hit = 1'b0;
      diag_len = 8'(qaid_pkg::DIAG_LEN);
      diag_byte = req_sub_in;
      fn_hit = 1'b0;
      fn_sel = 8'h00;
      case (req_path_in)
         qaid_pkg::PATH_RECORD: begin
            diag_hit = (req_addr_in == qaid_pkg::REC_DIAG_FULL)
                       || (req_addr_in == qaid_pkg::REC_DIAG_SHORT);
            if (req_addr_in == qaid_pkg::REC_DIAG_SHORT) begin
               diag_len = 8'(qaid_pkg::SHORT_LEN);
            end
            fn_sel = 8'(req_addr_in - qaid_pkg::REC_FN_BASE);
            fn_hit = (req_addr_in >= qaid_pkg::REC_FN_BASE)
                     && (fn_sel < 8'(NCH)) && (req_sub_in == 8'h00);
         end
         qaid_pkg::PATH_INDEX: begin
            diag_hit = (req_addr_in == qaid_pkg::IDX_DIAG_FULL)
                       || (req_addr_in == qaid_pkg::IDX_DIAG_SHORT);
            if (req_addr_in == qaid_pkg::IDX_DIAG_SHORT) begin
               diag_len = 8'(qaid_pkg::SHORT_LEN);
            end
            fn_sel = 8'(req_addr_in - qaid_pkg::IDX_FN_BASE);
            fn_hit = (req_addr_in >= qaid_pkg::IDX_FN_BASE)
                     && (fn_sel < 8'(NCH)) && (req_sub_in == 8'h00);
         end
         qaid_pkg::PATH_SUB: begin
            // one subindex per record byte
            diag_hit = (req_addr_in == qaid_pkg::IDX_SUB_DIAG)
                       && (req_sub_in >= qaid_pkg::SUB_DIAG_BASE);
            diag_byte = req_sub_in - qaid_pkg::SUB_DIAG_BASE;
            fn_sel = req_sub_in - qaid_pkg::SUB_FN_BASE;
            fn_hit = (req_addr_in == qaid_pkg::IDX_FN_BASE)
                     && (req_sub_in >= qaid_pkg::SUB_FN_BASE)
                     && (fn_sel < 8'(NCH));
         end
         default: begin
            diag_hit = 1'b0; // no such path
         end
      endcase
      diag_hit = diag_hit && (diag_byte < diag_len);
   end

   // function select takes writes; record is read only
   always_comb begin
      fn_wr = '0;
      if (req_valid_in && req_write_in && fn_hit) begin
         fn_wr[fn_sel[1:0]] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // answer register
   // ----------------------------------------------------------------
   // one answer per request, the cycle after it is taken
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rsp_valid_out <= 1'b0;
         rsp_data_out <= 8'h00;
         rsp_err_out <= 1'b0;
      end else begin
         rsp_valid_out <= req_valid_in;
         rsp_data_out <= 8'h00;
         rsp_err_out <= 1'b0;
         if (req_valid_in) begin
            if (fn_hit) begin
               rsp_data_out <= req_write_in ? 8'h00 : fn_r[fn_sel[1:0]];
            end else if (diag_hit && !req_write_in) begin
               rsp_data_out <= rec[diag_byte[4:0]];
            end else begin
               rsp_err_out <= 1'b1; // unmapped access or write to record refused
            end
         end
      end
   end
endmodule // qaid_top

// ===== testbench/qaid_host_model.sv
// head station model: one byte access per request on the access port
// assumes the core clock of the block; caller sits just after an edge
`timescale 1ns/100ps
module qaid_host_model (
   input wire logic core_clk_in, // core clock
   output logic req_valid_out, // request
   output logic req_write_out, // write
   output logic [1:0] req_path_out, // path
   output logic [15:0] req_addr_out, // record or index
   output logic [7:0] req_sub_out, // offset or subindex
   output logic [7:0] req_wdata_out // write byte
);
   // idle port at time zero
   initial begin
      {req_valid_out, req_write_out, req_path_out} = '0;
      {req_addr_out, req_sub_out, req_wdata_out} = '0;
   end
   // hold one request across the edge that takes it
   task automatic issue(input logic w, input logic [1:0] p,
      input logic [15:0] a, input logic [7:0] s, input logic [7:0] d);
      req_valid_out <= 1'b1;
      {req_write_out, req_path_out} <= {w, p};
      {req_addr_out, req_sub_out, req_wdata_out} <= {a, s, d};
      @(posedge core_clk_in);
   endtask
   // release: address flips so stale values are not trusted
   task automatic idle();
      req_valid_out <= 1'b0;
      req_addr_out <= ~req_addr_out;
   endtask
endmodule // qaid_host_model

// ===== testbench/qaid_checker.sv
// checker: access port answers, constant bytes, module indicator
// assumes it is bound onto qaid_top, single clock domain
`timescale 1ns/100ps
module qaid_checker #(
   parameter int unsigned NCH = 4 // channel count
) (
   input wire logic core_clk_in, // core clock
   input wire logic rst_in, // sync reset
   input wire logic module_fail_in, // failure pin
   input wire logic req_valid_in, // request
   input wire logic req_write_in, // write
   input wire logic [1:0] req_path_in, // path
   input wire logic [15:0] req_addr_in, // address
   input wire logic [7:0] req_sub_in, // offset
   input wire logic rsp_valid_out, // answer
   input wire logic [7:0] rsp_data_out, // byte
   input wire logic rsp_err_out, // refused
   input wire logic module_led_out // module led
);
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   // reads through the record number path
   wire rd = req_valid_in && !req_write_in && req_path_in == 2'h0;
   wire rd1 = rd && req_addr_in == 16'h0001;
   a_answer_next: assert property (req_valid_in |=> rsp_valid_out)
      else $error("request not answered");
   a_quiet_idle: assert property (!req_valid_in |=> !rsp_valid_out)
      else $error("answer without request");
   a_short_refuse: assert property (rd && req_addr_in == 16'h0000
      && req_sub_in >= 8'h04 |=> rsp_err_out && rsp_data_out == 8'h00)
      else $error("short record overrun");
   a_full_ok: assert property (rd1 && req_sub_in < 8'h14
      |=> rsp_valid_out && !rsp_err_out) else $error("full read refused");
   a_modinfo_val: assert property (rd1 && req_sub_in == 8'h01
      |=> rsp_data_out == 8'h15) else $error("module info wrong");
   a_kind_val: assert property (rd1 && req_sub_in == 8'h04
      |=> rsp_data_out == 8'h71) else $error("channel kind wrong");
   a_nbits_val: assert property (rd1 && req_sub_in == 8'h05
      |=> rsp_data_out == 8'h08) else $error("bit count wrong");
   a_nch_val: assert property (rd1 && req_sub_in == 8'h06
      |=> rsp_data_out == 8'h04) else $error("channel count wrong");
   a_reserved_zero: assert property (rd1 && (req_sub_in == 8'h02
      || req_sub_in inside {[8'h0C:8'h0F]}) |=> rsp_data_out == 8'h00)
      else $error("reserved byte not zero");
   a_fail_led: assert property (module_fail_in [*4]
      |-> module_led_out) else $error("module led off");
endmodule // qaid_checker

// ===== testbench/qaid_top_test.sv
// top bench: record access, scaling and diagnostic flags
// assumes qaid_pkg, host model and checker are compiled first
`timescale 1ns/100ps
module qaid_top_test;
   logic clk = 1'b0; // core clock
   logic rst = 1'b1; // sync reset
   logic stb = 1'b0; // sample strobe
   logic [63:0] mv = '0; // samples
   logic [3:0] pin = '0; // comm, ovfl, aux, fail
   logic rv, rw, rsp_v, rsp_e, mled; // port bits
   logic [1:0] rp; // path
   logic [15:0] ra; // address
   logic [7:0] rs, rd, rsp_d; // sub, wdata, answer
   logic [63:0] val; // scaled values
   logic [3:0] led; // channel leds
   int miscompares = 0; // mismatches
   int check_count = 0; // comparisons
   int seed = int'(32'h87DE59EA); // random seed
   int r; // random sample
   logic [8:0] exp_q[$]; // expected err and byte
   logic [7:0] rec0 [20] = '{1: 8'h15, 4: 8'h71, 5: 8'h08, 6: 8'h04,
      default: 8'h00}; // record after reset
   always #5 clk = ~clk;
   qaid_top #(.NCH(4)) dut (.core_clk_in(clk), .rst_in(rst),
      .sample_stb_in(stb), .sample_mv_in(mv), .module_fail_in(pin[0]),
      .aux_missing_in(pin[1]), .diag_ovfl_in(pin[2]), .comm_err_in(pin[3]),
      .req_valid_in(rv), .req_write_in(rw), .req_path_in(rp),
      .req_addr_in(ra), .req_sub_in(rs), .req_wdata_in(rd),
      .rsp_valid_out(rsp_v), .rsp_data_out(rsp_d), .rsp_err_out(rsp_e),
      .value_out(val), .chan_led_out(led), .module_led_out(mled));
   qaid_host_model host (.core_clk_in(clk), .req_valid_out(rv),
      .req_write_out(rw), .req_path_out(rp), .req_addr_out(ra),
      .req_sub_out(rs), .req_wdata_out(rd));
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // note the answer, then issue the request
   task automatic acc(input logic w, input logic [1:0] p,
      input logic [15:0] a, input logic [7:0] s, input logic [7:0] d,
      input logic [8:0] e);
      exp_q.push_back(e);
      host.issue(w, p, a, s, d);
   endtask
   // one strobe; ch2 repeats ch0 and ch3 repeats ch1
   task automatic smp(input int a0, input int a1);
      mv <= {a1[15:0], a0[15:0], a1[15:0], a0[15:0]};
      stb <= 1'b1;
      @(posedge clk);
      stb <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   function automatic logic [15:0] scale(input longint m, input longint g);
      return 16'((m * g) >>> 16);
   endfunction
   task automatic print_verdict();
      if (miscompares == 0 && check_count > 0 && exp_q.size() == 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // monitor: each answer against the oldest note
   always @(negedge clk) begin
      if (rsp_v === 1'b1)
         chk({7'h00, rsp_e, rsp_d}, {7'h00, exp_q.pop_front()});
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 20; i++)
         acc(0, 0, 16'h0001, i[7:0], 0, {1'b0, rec0[i]});
      acc(0, 0, 16'h0000, 8'h03, 0, 9'h000);
      acc(0, 0, 16'h0000, 8'h04, 0, 9'h100);
      acc(0, 1, 16'h2F00, 8'h01, 0, 9'h015);
      acc(0, 1, 16'h2F00, 8'h04, 0, 9'h100);
      acc(0, 1, 16'h2F01, 8'h14, 0, 9'h100);
      acc(0, 2, 16'h5005, 8'h06, 0, 9'h071);
      acc(1, 0, 16'h0001, 8'h00, 8'h55, 9'h100);
      acc(1, 1, 16'h3100, 8'h00, 8'h10, 9'h000);
      acc(1, 0, 16'h0081, 8'h00, 8'h20, 9'h000);
      acc(1, 2, 16'h3100, 8'h03, 8'hFF, 9'h000);
      acc(1, 1, 16'h3103, 8'h00, 8'h33, 9'h000);
      acc(0, 0, 16'h0081, 8'h00, 0, 9'h020);
      host.idle();
      smp(10000, 0);
      chk(val[15:0], 16'h6C00);
      for (int k = 0; k < 8; k++) begin
         r = $unsigned($random(seed)) % 10001;
         smp(r, r);
         chk(val[15:0], scale(r, qaid_pkg::GAIN_A));
         chk(val[31:16], scale(r, qaid_pkg::GAIN_B));
         chk(val[47:32], 16'h0000);
      end
      smp(12000, -3000);
      chk(val[31:0], 32'hF3337EFF);
      smp(-2000, 13000);
      chk(val[31:0], 32'h5000ED00);
      pin <= 4'hF;
      repeat (5) @(posedge clk);
      chk({11'h000, mled, led}, 16'h001B);
      acc(0, 0, 16'h0001, 8'h00, 0, 9'h09F);
      acc(0, 0, 16'h0001, 8'h03, 0, 9'h018);
      acc(0, 0, 16'h0001, 8'h07, 0, 9'h00B);
      for (int c = 0; c < 4; c++)
         acc(0, 2, 16'h5005, 8'h0A + c[7:0], 0,
            9'(32'h01008040 >> (8 * c)) & 9'h0FF);
      host.idle();
      repeat (3) @(posedge clk);
      print_verdict();
   end
   // watchdog for a hung run
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      print_verdict();
   end
endmodule // qaid_top_test
bind qaid_top qaid_checker #(.NCH(NCH)) u_chk (.core_clk_in, .rst_in,
   .module_fail_in, .req_valid_in, .req_write_in, .req_path_in,
   .req_addr_in, .req_sub_in, .rsp_valid_out, .rsp_data_out,
   .rsp_err_out, .module_led_out);
